// [common/evphy_pkg.sv]
// constants for the emulated phy basic control register block
// assumes a 50 MHz system clock and a clause 22 management link
package evphy_pkg;
  localparam logic [11:0] CTRL_OFFSET = 12'h1C0;
  localparam logic [4:0] MDIO_CTRL_INDEX = 5'h00;
  localparam int SOFT_RESET_BIT_POS = 15;
  localparam int LOOPBACK_BIT_POS = 14;
  localparam int SPEED_LOW_BIT_POS = 13;
  localparam int AUTONEG_EN_BIT_POS = 12;
  localparam int POWER_DOWN_BIT_POS = 11;
  localparam int ISOLATE_BIT_POS = 10;
  localparam int RESTART_BIT_POS = 9;
  localparam int DUPLEX_BIT_POS = 8;
  localparam int COL_TEST_BIT_POS = 7;
  localparam logic [15:0] CTRL_RESET = 16'h1000;
  localparam logic [15:0] CTRL_WMASK = 16'h7F80;
  localparam logic [15:0] MM_PAD_ZERO = 16'h0000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int AN_TIME_NS = 1000;
  localparam int AN_CYCLES = (AN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] AN_LAST = 8'(AN_CYCLES - 1);
  localparam int PREAMBLE_LEN = 32;
  localparam int HDR_LEN = 13;
  localparam int DATA_LEN = 16;
  localparam logic [5:0] PRE_MIN = 6'(PREAMBLE_LEN);
  localparam logic [3:0] HDR_LAST = 4'(HDR_LEN - 1);
  localparam logic [3:0] DATA_LAST = 4'(DATA_LEN - 1);
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam int MIRROR_W = 21;
  typedef enum logic [3:0] {
    EVPHY_PRE = 4'h1,
    EVPHY_HDR = 4'h2,
    EVPHY_TA = 4'h4,
    EVPHY_DAT = 4'h8
  } evphy_mdio_state_type;
endpackage

// [common/evphy_xfer_if.sv]
// clock crossing signals between system side and management link side
// both halves use toggle handshakes; mirror data held stable while its toggle is open, write data is not
`timescale 1ns/1ps
interface evphy_xfer_if;
  logic [20:0] mirror_data;
  logic mirror_req;
  logic mirror_ack;
  logic [15:0] wr_data;
  logic wr_req;
  logic wr_ack;
  modport sys (output mirror_data, output mirror_req, input mirror_ack,
    input wr_data, input wr_req, output wr_ack);
  modport link (input mirror_data, input mirror_req, output mirror_ack,
    output wr_data, output wr_req, input wr_ack);
endinterface

// [hdl/evphy_mdio.sv]
// clause 22 management slave running on the management clock
// assumes rst_n_i from the system domain; it is resynchronised here
`timescale 1ns/1ps
module evphy_mdio
  import evphy_pkg::*;
(
  input wire logic clk_mdc_i,
  input wire logic rst_n_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n_o,
  evphy_xfer_if.link xfer
);
  logic rst_s1, rst_s2, req_s1, req_s2;
  logic [20:0] shadow;
  logic [12:0] hdr;
  logic [12:0] full;
  logic [15:0] sh;
  logic [5:0] cnt;
  logic rd_hit, wr_hit;
  evphy_mdio_state_type state;

  assign full = {hdr[11:0], mdio_i};

  always_ff @(posedge clk_mdc_i) begin
    rst_s1 <= rst_n_i;
    rst_s2 <= rst_s1;
    req_s1 <= xfer.mirror_req;
    req_s2 <= req_s1;
  end

  // local copy of {strap address, control register}
  always_ff @(posedge clk_mdc_i) begin
    if (!rst_s2) begin
      shadow <= '0;
      xfer.mirror_ack <= 1'b0;
    end else if (req_s2 != xfer.mirror_ack) begin
      shadow <= xfer.mirror_data;
      xfer.mirror_ack <= req_s2;
    end
  end

  always_ff @(posedge clk_mdc_i) begin
    if (!rst_s2) begin
      state <= EVPHY_PRE;
      cnt <= '0;
      hdr <= '0;
      sh <= '0;
      rd_hit <= 1'b0;
      wr_hit <= 1'b0;
      mdio_o <= 1'b1;
      mdio_oe_n_o <= 1'b1;
      xfer.wr_data <= '0;
      xfer.wr_req <= 1'b0;
    end else begin
      unique case (state)
        EVPHY_PRE: begin
          if (mdio_i) begin
            if (cnt != PRE_MIN) cnt <= cnt + 6'h01;
          end else begin
            if (cnt == PRE_MIN) state <= EVPHY_HDR;
            cnt <= '0;
          end
        end
        EVPHY_HDR: begin
          hdr <= full;
          cnt <= cnt + 6'h01;
          if (cnt[3:0] == HDR_LAST) begin
            state <= EVPHY_TA;
            cnt <= '0;
            // only frames to the strapped address are answered
            rd_hit <= full[12] && full[11:10] == MDIO_OP_READ && full[9:5] == shadow[20:16];
            wr_hit <= full[12] && full[11:10] == MDIO_OP_WRITE && full[9:5] == shadow[20:16];
          end
        end
        EVPHY_TA: begin
          cnt <= cnt + 6'h01;
          if (cnt == 6'h00) begin
            // 16-bit view only; pads never leave the chip
            sh <= (hdr[4:0] == MDIO_CTRL_INDEX) ? shadow[15:0] : 16'h0000;
            if (rd_hit) begin
              mdio_o <= 1'b0;
              mdio_oe_n_o <= 1'b0;
            end
          end else begin
            state <= EVPHY_DAT;
            cnt <= '0;
            if (rd_hit) begin
              mdio_o <= sh[15];
              sh <= {sh[14:0], 1'b0};
            end
          end
        end
        EVPHY_DAT: begin
          cnt <= cnt + 6'h01;
          sh <= {sh[14:0], mdio_i};
          if (rd_hit) mdio_o <= sh[15];
          if (cnt[3:0] == DATA_LAST) begin
            state <= EVPHY_PRE;
            cnt <= '0;
            mdio_oe_n_o <= 1'b1;
            // isolation never gates this path
            if (wr_hit && hdr[4:0] == MDIO_CTRL_INDEX) begin
              xfer.wr_data <= {sh[14:0], mdio_i};
              xfer.wr_req <= ~xfer.wr_req;
            end
          end
        end
        default: state <= EVPHY_PRE;
      endcase
    end
  end
endmodule

// [hdl/evphy_ctrl.sv]
// emulated phy basic control register, memory mapped and over management link
// assumes fabric and loader ports on clk_sys_i; mii, strap pins asynchronous
//
// Summary of operation
// - bit 15 restores defaults, self clearing
// - loopback returns mac frames, blocks fabric
// - manual speed bit: 10 or 100
// - autoneg enable overrides manual speed, duplex
// - bit 11 stored, no effect
// - isolate floats mii outputs, ignores inputs
// - isolate ignored in mac mode
// - management pin never isolated
// - restart bit reruns emulated autonegotiation
// - manual duplex bit: half or full
// - collision test: col follows mac transmit
// - bit 6 and 5:0 read zero
// - upper half padding; serial view 16 bits
// - loader overwrites whole register
// - offset 1C0h, serial index zero
// - serial answers only strapped phy address
// - autoneg done low after reset, then high
`timescale 1ns/1ps
module evphy_ctrl
  import evphy_pkg::*;
#(
  parameter bit AN_SPEED_100 = 1'b1,
  parameter bit AN_FULL_DUPLEX = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_mdc_i,
  input wire logic [11:0] mm_addr_i,
  input wire logic mm_wr_i,
  input wire logic mm_rd_i,
  input wire logic [31:0] mm_wdata_i,
  output logic [31:0] mm_rdata_o,
  output logic mm_rvalid_o,
  input wire logic loader_wr_i,
  input wire logic [15:0] loader_data_i,
  input wire logic [4:0] phy_addr_strap_i,
  input wire logic mac_mode_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n_o,
  input wire logic [3:0] mac_txd_i,
  input wire logic mac_tx_en_i,
  output logic [3:0] mac_rxd_o,
  output logic mac_rx_dv_o,
  output logic mac_col_o,
  output logic mii_oe_n_o,
  output logic mii_pull_en_o,
  output logic [3:0] fabric_txd_o,
  output logic fabric_tx_en_o,
  input wire logic [3:0] fabric_rxd_i,
  input wire logic fabric_rx_dv_i,
  output logic speed_100_o,
  output logic full_duplex_o,
  output logic autoneg_done_o
);
  evphy_xfer_if xfer ();

  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [15:0] wdat;
  logic wsel;
  logic mm_wr_hit;
  logic mdio_pend;
  logic mdio_take;
  logic an_start;
  logic an_finish;
  logic an_busy;
  logic [7:0] an_cnt;
  logic an_speed;
  logic an_duplex;
  logic [4:0] strap_s1, strap_s2, phy_addr;
  logic strap_taken;
  logic mode_s1, mac_mode_s;
  logic [3:0] txd_s1, txd_s;
  logic txen_s1, txen_s;
  logic isolated;
  logic tx_en_eff;
  logic wreq_s1, wreq_s2;
  logic mack_s1, mack_s2;
  logic [20:0] mirror_now;

  evphy_mdio u_mdio (
    .clk_mdc_i(clk_mdc_i),
    .rst_n_i(rst_n_i),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_n_o(mdio_oe_n_o),
    .xfer(xfer.link)
  );

  // pin synchronisers
  always_ff @(posedge clk_sys_i) begin
    strap_s1 <= phy_addr_strap_i;
    strap_s2 <= strap_s1;
    mode_s1 <= mac_mode_i;
    mac_mode_s <= mode_s1;
    txd_s1 <= mac_txd_i;
    txd_s <= txd_s1;
    txen_s1 <= mac_tx_en_i;
    txen_s <= txen_s1;
    wreq_s1 <= xfer.wr_req;
    wreq_s2 <= wreq_s1;
    mack_s1 <= xfer.mirror_ack;
    mack_s2 <= mack_s1;
  end

  // strap caught once after reset release
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      phy_addr <= 5'h00;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      phy_addr <= strap_s2;
      strap_taken <= 1'b1;
    end
  end

  assign mm_wr_hit = mm_wr_i && mm_addr_i == CTRL_OFFSET;
  assign mdio_pend = wreq_s2 != xfer.wr_ack;

  // write source priority: loader, memory map, management link
  always_comb begin
    wsel = 1'b1;
    wdat = loader_data_i;
    mdio_take = 1'b0;
    if (loader_wr_i) begin
      wdat = loader_data_i;
    end else if (mm_wr_hit) begin
      wdat = mm_wdata_i[15:0];
    end else if (mdio_pend) begin
      wdat = xfer.wr_data;
      mdio_take = 1'b1;
    end else begin
      wsel = 1'b0;
    end
  end

  assign an_start = wsel && (wdat[SOFT_RESET_BIT_POS] || wdat[RESTART_BIT_POS]);
  assign an_finish = an_busy && an_cnt == AN_LAST && !an_start;

  always_comb begin
    next_ctrl = ctrl;
    if (an_finish) next_ctrl[RESTART_BIT_POS] = 1'b0;
    if (wsel) begin
      if (wdat[SOFT_RESET_BIT_POS]) next_ctrl = CTRL_RESET;
      else next_ctrl = wdat & CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) ctrl <= CTRL_RESET;
    else ctrl <= next_ctrl;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) xfer.wr_ack <= 1'b0;
    else if (mdio_take) xfer.wr_ack <= wreq_s2;
  end

  // emulated negotiation: runs after reset, soft reset or restart
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      an_busy <= 1'b1;
      an_cnt <= 8'h00;
      autoneg_done_o <= 1'b0;
      an_speed <= 1'b0;
      an_duplex <= 1'b0;
    end else if (an_start) begin
      an_busy <= 1'b1;
      an_cnt <= 8'h00;
      autoneg_done_o <= 1'b0;
    end else if (an_busy) begin
      an_cnt <= an_cnt + 8'h01;
      if (an_finish) begin
        an_busy <= 1'b0;
        autoneg_done_o <= 1'b1;
        an_speed <= AN_SPEED_100;
        an_duplex <= AN_FULL_DUPLEX;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      speed_100_o <= 1'b0;
      full_duplex_o <= 1'b0;
    end else if (ctrl[AUTONEG_EN_BIT_POS]) begin
      speed_100_o <= an_speed;
      full_duplex_o <= an_duplex;
    end else begin
      speed_100_o <= ctrl[SPEED_LOW_BIT_POS];
      full_duplex_o <= ctrl[DUPLEX_BIT_POS];
    end
  end

  // memory mapped read
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      mm_rdata_o <= 32'h0000_0000;
      mm_rvalid_o <= 1'b0;
    end else begin
      mm_rvalid_o <= mm_rd_i;
      if (mm_rd_i && mm_addr_i == CTRL_OFFSET) mm_rdata_o <= {MM_PAD_ZERO, ctrl};
      else mm_rdata_o <= 32'h0000_0000;
    end
  end

  // publish register and strap address to the link side
  assign mirror_now = {phy_addr, ctrl};
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      xfer.mirror_req <= 1'b0;
      xfer.mirror_data <= '0;
    end else if (xfer.mirror_req == mack_s2 && xfer.mirror_data != mirror_now) begin
      xfer.mirror_data <= mirror_now;
      xfer.mirror_req <= ~xfer.mirror_req;
    end
  end

  // mii data path
  assign isolated = ctrl[ISOLATE_BIT_POS] && !mac_mode_s;
  assign tx_en_eff = txen_s && !isolated;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      fabric_tx_en_o <= 1'b0;
      fabric_txd_o <= 4'h0;
      mac_rx_dv_o <= 1'b0;
      mac_rxd_o <= 4'h0;
      mac_col_o <= 1'b0;
      mii_oe_n_o <= 1'b0;
      mii_pull_en_o <= 1'b1;
    end else begin
      mii_oe_n_o <= isolated;
      mii_pull_en_o <= !isolated;
      mac_col_o <= ctrl[COL_TEST_BIT_POS] && tx_en_eff;
      if (ctrl[LOOPBACK_BIT_POS]) begin
        fabric_tx_en_o <= 1'b0;
        fabric_txd_o <= 4'h0;
        mac_rx_dv_o <= tx_en_eff;
        mac_rxd_o <= tx_en_eff ? txd_s : 4'h0;
      end else begin
        fabric_tx_en_o <= tx_en_eff;
        fabric_txd_o <= tx_en_eff ? txd_s : 4'h0;
        mac_rx_dv_o <= fabric_rx_dv_i && !isolated;
        mac_rxd_o <= isolated ? 4'h0 : fabric_rxd_i;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  localparam int AN_WAIT = AN_CYCLES;

  // cycles since the last negotiation start, saturating
  logic [7:0] an_age;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || an_start) an_age <= 8'h00;
    else if (!(&an_age)) an_age <= an_age + 8'h01;
  end

  AST_SOFT_RESET: assert property (
    mm_wr_hit && !loader_wr_i && mm_wdata_i[SOFT_RESET_BIT_POS]
      |=> ctrl == CTRL_RESET && !autoneg_done_o)
    else $error("soft reset did not restore defaults");
  AST_LOOP_BLOCK: assert property (
    ctrl[LOOPBACK_BIT_POS] && $stable(ctrl) |=> !fabric_tx_en_o)
    else $error("frame forwarded during loopback");
  AST_LOOP_ECHO: assert property (
    ctrl[LOOPBACK_BIT_POS] |=> mac_rx_dv_o == $past(tx_en_eff))
    else $error("loopback did not echo transmit enable");
  AST_MANUAL_SPEED: assert property (
    !ctrl[AUTONEG_EN_BIT_POS] ##1 !ctrl[AUTONEG_EN_BIT_POS]
      |-> speed_100_o == $past(ctrl[SPEED_LOW_BIT_POS]))
    else $error("manual speed not applied");
  AST_AN_OVERRIDE: assert property (
    ctrl[AUTONEG_EN_BIT_POS] && $stable(an_speed) |=> speed_100_o == $past(an_speed))
    else $error("manual speed leaked through autoneg");
  AST_POWER_BIT: assert property (
    mm_wr_hit && !loader_wr_i && !mm_wdata_i[SOFT_RESET_BIT_POS]
      |=> ctrl[POWER_DOWN_BIT_POS] == $past(mm_wdata_i[POWER_DOWN_BIT_POS]))
    else $error("power down bit not stored");
  AST_ISOLATE: assert property (
    isolated |=> mii_oe_n_o && !mii_pull_en_o && !mac_col_o && !fabric_tx_en_o)
    else $error("isolated pins still active");
  AST_MAC_MODE: assert property (
    mac_mode_s |=> !mii_oe_n_o && mii_pull_en_o)
    else $error("isolate acted in mac mode");
  AST_DUPLEX: assert property (
    !ctrl[AUTONEG_EN_BIT_POS] ##1 !ctrl[AUTONEG_EN_BIT_POS]
      |-> full_duplex_o == $past(ctrl[DUPLEX_BIT_POS]))
    else $error("manual duplex not applied");
  AST_COL_TEST: assert property (
    ctrl[COL_TEST_BIT_POS] && tx_en_eff |=> mac_col_o)
    else $error("collision test missing");
  AST_COL_CAUSE: assert property (
    mac_col_o |-> $past(ctrl[COL_TEST_BIT_POS]) && $past(tx_en_eff))
    else $error("collision without cause");
  AST_READ_PAD: assert property (
    mm_rvalid_o |-> mm_rdata_o[31:16] == MM_PAD_ZERO && mm_rdata_o[6:0] == 7'h00)
    else $error("reserved bits read nonzero");
  AST_LOADER: assert property (
    loader_wr_i && !loader_data_i[SOFT_RESET_BIT_POS]
      |=> ctrl == ($past(loader_data_i) & CTRL_WMASK))
    else $error("loader did not overwrite register");
  AST_AN_TIME: assert property (
    an_age >= 8'(AN_WAIT) |-> autoneg_done_o)
    else $error("autoneg not done in time");
  AST_AN_CLEARED: assert property (
    an_start |=> !autoneg_done_o)
    else $error("autoneg done not cleared on restart");
  AST_RESTART_CLEAR: assert property (
    $rose(autoneg_done_o) |-> !ctrl[RESTART_BIT_POS])
    else $error("restart bit still set after results");

  COV_LOOPBACK: cover property (ctrl[LOOPBACK_BIT_POS] && mac_rx_dv_o);
  COV_SOFT_RESET: cover property (mm_wr_hit && mm_wdata_i[SOFT_RESET_BIT_POS]);
  COV_AN_DONE: cover property ($rose(autoneg_done_o));
  COV_MDIO_WRITE: cover property (mdio_take);
  COV_ISOLATED: cover property (isolated && txen_s);
endmodule

// [test/evphy_mac_model.sv]
// behavioural external mac on the phy-side data port of the control block
// assumes the bench clock; transmit changes on the falling edge
`timescale 1ns/1ps
module evphy_mac_model (
  input wire logic clk_i,
  input wire logic [3:0] rxd_i,
  input wire logic rx_dv_i,
  input wire logic col_i,
  output logic [3:0] txd_o,
  output logic tx_en_o
);
  int rx_cnt = 0;
  int rx_sum = 0;
  int col_cnt = 0;

  initial begin
    tx_en_o = 1'b0;
    txd_o = 4'hA;
  end

  task clear();
    rx_cnt = 0;
    rx_sum = 0;
    col_cnt = 0;
  endtask

  // nibbles 1..n, then idle with inverted data so stale values never match
  task send(input int n);
    for (int i = 1; i <= n; i++) begin
      @(negedge clk_i);
      tx_en_o = 1'b1;
      txd_o = 4'(i);
    end
    @(negedge clk_i);
    tx_en_o = 1'b0;
    txd_o = ~txd_o;
  endtask

  // sampled mid-cycle, away from the edge that launches the outputs
  always @(negedge clk_i) begin
    if (rx_dv_i === 1'b1) begin
      rx_cnt++;
      rx_sum += int'(rxd_i);
    end
    if (col_i === 1'b1) begin
      col_cnt++;
    end
  end
endmodule

// [test/emulated_phy_basic_control_test.sv]
// self-checking bench for the emulated phy basic control register
// assumes evphy_ctrl with default autoneg result of 100 full duplex
`timescale 1ns/1ps
module emulated_phy_basic_control_test;
  import evphy_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, clk_mdc_i = 0;
  logic [11:0] mm_addr_i = 12'h000;
  logic mm_wr_i = 0, mm_rd_i = 0, loader_wr_i = 0, mac_mode_i = 0;
  logic [31:0] mm_wdata_i = 32'h0;
  logic [15:0] loader_data_i = 16'h0;
  logic [4:0] strap = 5'h05;
  logic [3:0] fab_rxd = 4'h0;
  logic fab_dv = 1'b0;
  logic mdio_drv = 1'b1;
  wire logic mdio_i;
  logic [31:0] mm_rdata_o;
  logic [3:0] mac_txd, mac_rxd_o, fabric_txd_o;
  logic mm_rvalid_o, mdio_o, mdio_oe_n_o, mac_tx_en, mac_rx_dv_o, mac_col_o, mii_oe_n_o;
  logic mii_pull_en_o, fabric_tx_en_o, speed_100_o, full_duplex_o, autoneg_done_o;
  int errors = 0, n_tests = 0, fab_cnt = 0, fab_sum = 0;
  logic [31:0] d;
  logic [15:0] md;
  logic drove;

  always #10 clk_sys_i = ~clk_sys_i;
  // pulled-up management wire
  assign mdio_i = (mdio_oe_n_o === 1'b0) ? mdio_o : mdio_drv;
  always @(negedge clk_sys_i) begin
    if (fabric_tx_en_o === 1'b1) begin
      fab_cnt++;
      fab_sum += int'(fabric_txd_o);
    end
  end

  evphy_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_mdc_i(clk_mdc_i),
    .mm_addr_i(mm_addr_i), .mm_wr_i(mm_wr_i), .mm_rd_i(mm_rd_i), .mm_wdata_i(mm_wdata_i),
    .mm_rdata_o(mm_rdata_o), .mm_rvalid_o(mm_rvalid_o), .loader_wr_i(loader_wr_i),
    .loader_data_i(loader_data_i), .phy_addr_strap_i(strap), .mac_mode_i(mac_mode_i),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .mac_txd_i(mac_txd),
    .mac_tx_en_i(mac_tx_en), .mac_rxd_o(mac_rxd_o), .mac_rx_dv_o(mac_rx_dv_o),
    .mac_col_o(mac_col_o), .mii_oe_n_o(mii_oe_n_o), .mii_pull_en_o(mii_pull_en_o),
    .fabric_txd_o(fabric_txd_o), .fabric_tx_en_o(fabric_tx_en_o), .fabric_rxd_i(fab_rxd),
    .fabric_rx_dv_i(fab_dv), .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o),
    .autoneg_done_o(autoneg_done_o));

  evphy_mac_model mac (.clk_i(clk_sys_i), .rxd_i(mac_rxd_o), .rx_dv_i(mac_rx_dv_o),
    .col_i(mac_col_o), .txd_o(mac_txd), .tx_en_o(mac_tx_en));

  task finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task chkf(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task mm_wr(input logic [11:0] a, input logic [31:0] v);
    @(negedge clk_sys_i);
    mm_addr_i = a;
    mm_wdata_i = v;
    mm_wr_i = 1'b1;
    @(negedge clk_sys_i);
    mm_wr_i = 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk_sys_i);
    mm_addr_i = a;
    mm_rd_i = 1'b1;
    @(negedge clk_sys_i);
    chkf("rvalid", 1'b1, mm_rvalid_o);
    chk("rdata", exp, mm_rdata_o);
    mm_rd_i = 1'b0;
  endtask

  // one frame, read or write; the clock stands still between frames
  task mdio_frame(input logic [4:0] pa, input logic [1:0] op, input logic [15:0] wd);
    logic [63:0] frm;
    frm = {32'hFFFF_FFFF, 2'b01, op, pa, MDIO_CTRL_INDEX, 2'b10, wd};
    drove = 1'b0;
    md = 16'h0;
    for (int k = 0; k < 64; k++) begin
      mdio_drv = frm[63-k];
      #7.5 clk_mdc_i = 1'b1;
      #7.5 clk_mdc_i = 1'b0;
      if (mdio_oe_n_o === 1'b0) drove = 1'b1;
      if (k >= 47 && k <= 62) md = {md[14:0], mdio_o};
    end
    mdio_drv = 1'b1;
    chkf("mdio released", 1'b1, mdio_oe_n_o);
  endtask

  task clr();
    mac.clear();
    fab_cnt = 0;
    fab_sum = 0;
  endtask

  task counts(input int fab, input int rx, input int col);
    cyc(8);
    chk("fabric nibbles", 32'(fab), 32'(fab_cnt));
    chk("rx nibbles", 32'(rx), 32'(mac.rx_cnt));
    chk("col cycles", 32'(col), 32'(mac.col_cnt));
  endtask

  task tend(input string nm);
    $display("test %s done", nm);
  endtask

  initial begin
    int i;
    // link side needs clock edges after release to leave its reset
    for (int j = 0; j < 7; j++) begin
      if (j == 4) rst_n_i = 1'b1;
      #7.5 clk_mdc_i = 1'b1;
      #7.5 clk_mdc_i = 1'b0;
    end
    chkf("an done early", 1'b0, autoneg_done_o);
    for (i = 0; i < 60 && autoneg_done_o !== 1'b1; i++) @(negedge clk_sys_i);
    if (i == 60) begin
      errors++;
      finish_test();
    end
    rd_chk(CTRL_OFFSET, 32'h0000_1000);
    chkf("an speed", 1'b1, speed_100_o);
    chkf("an duplex", 1'b1, full_duplex_o);
    tend("reset");
    mm_wr(CTRL_OFFSET, 32'hFFFF_7FFF);
    rd_chk(CTRL_OFFSET, 32'h0000_7F80);
    cyc(60);
    rd_chk(CTRL_OFFSET, 32'h0000_7D80);
    tend("access");
    for (int k = 0; k < 4; k++) begin
      mm_wr(CTRL_OFFSET, {18'h0, k[1], 4'h0, k[0], 8'h00});
      cyc(3);
      chkf("manual speed", k[1], speed_100_o);
      chkf("manual duplex", k[0], full_duplex_o);
    end
    mm_wr(CTRL_OFFSET, 32'h0000_1000);
    cyc(3);
    chkf("override speed", 1'b1, speed_100_o);
    chkf("override duplex", 1'b1, full_duplex_o);
    tend("speed");
    mm_wr(12'h1C4, 32'h0000_4000);
    rd_chk(CTRL_OFFSET, 32'h0000_1000);
    rd_chk(12'h1C4, 32'h0);
    mm_wr(CTRL_OFFSET, 32'h0000_4080);
    mm_wr(CTRL_OFFSET, 32'h0000_8000);
    rd_chk(CTRL_OFFSET, 32'h0000_1000);
    tend("soft reset");
    clr();
    mac.send(4);
    counts(4, 0, 0);
    chk("fabric sum", 32'd10, 32'(fab_sum));
    clr();
    @(negedge clk_sys_i);
    fab_rxd = 4'h3;
    fab_dv = 1'b1;
    cyc(2);
    fab_dv = 1'b0;
    counts(0, 2, 0);
    chk("fabric rx sum", 32'd6, 32'(mac.rx_sum));
    mm_wr(CTRL_OFFSET, 32'h0000_4080); // loopback together with collision test
    clr();
    // fabric traffic must stay away from the mac in loopback
    fab_dv = 1'b1;
    mac.send(5);
    fab_dv = 1'b0;
    counts(0, 5, 5);
    chk("rx sum", 32'd15, 32'(mac.rx_sum));
    tend("loopback");
    mm_wr(CTRL_OFFSET, 32'h0000_4400);
    cyc(3);
    chkf("oe isolated", 1'b1, mii_oe_n_o);
    chkf("pull isolated", 1'b0, mii_pull_en_o);
    clr();
    mac.send(3);
    counts(0, 0, 0);
    mdio_frame(strap, MDIO_OP_READ, 16'hFFFF);
    chk("mdio data", 32'h0000_4400, {16'h0, md});
    mdio_frame(strap + 5'h1, MDIO_OP_READ, 16'hFFFF);
    chkf("mdio foreign", 1'b0, drove);
    mdio_frame(strap + 5'h1, MDIO_OP_WRITE, 16'h0000);
    mdio_frame(strap, MDIO_OP_WRITE, 16'h4C00);
    cyc(6);
    rd_chk(CTRL_OFFSET, 32'h0000_4C00);
    cyc(1);
    mac_mode_i = 1'b1;
    cyc(4);
    chkf("oe mac mode", 1'b0, mii_oe_n_o);
    chkf("pull mac mode", 1'b1, mii_pull_en_o);
    clr();
    mac.send(3);
    counts(0, 3, 0);
    tend("isolate");
    @(negedge clk_sys_i);
    loader_data_i = 16'h0100;
    loader_wr_i = 1'b1;
    mm_addr_i = CTRL_OFFSET;
    mm_wdata_i = 32'h0000_4000;
    mm_wr_i = 1'b1;
    @(negedge clk_sys_i);
    loader_wr_i = 1'b0;
    mm_wr_i = 1'b0;
    rd_chk(CTRL_OFFSET, 32'h0000_0100);
    tend("loader");
    finish_test();
  end
endmodule
